// >>> rtl/fcd_host.sv
// Implementation choice: the AXI4-Lite register port.
`include "fcd_map.svh"
`default_nettype none
module fcd_host
    import fcd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    fcd_if.host bus
);
    fcd_host_st_t s_r;
    fcd_host_st_t s_nxt;
    logic [15:0] wmask;
    logic [15:0] wmerged;
    logic [15:0] patched;

    assign wmask = {{8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}};
    assign wmerged = s_r.w_data[15:0] & wmask;

    always_comb begin
        patched = s_r.wdata;
        case (s_r.ctrl[7:0])
            `FCD_OFS_SUPPLY: patched[`FCD_BIT_SUP_HI:`FCD_BIT_SUP_LO] = s_r.sup;
            `FCD_OFS_NUM_HI: patched[7:0] = `FCD_NUM_HI_RSV;
            `FCD_OFS_DIVSEL: begin
                patched[`FCD_BIT_RSV7] = 1'b0;
                patched[`FCD_BIT_RSV3] = 1'b0;
            end
            default: patched = s_r.wdata;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        if (bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (awvalid && awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = wdata;
            s_nxt.w_strb = wstrb;
        end
        if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `FCD_RESP_OK;
            case (s_r.aw_addr)
                `FCD_AXI_CTRL: begin
                    s_nxt.ctrl[8:0] = (s_r.ctrl[8:0] & ~wmask[8:0]) | wmerged[8:0];
                    if (s_r.w_strb[1] && s_r.w_data[`FCD_CTRL_GO]) begin
                        if (s_r.busy) begin
                            s_nxt.refused = 1'b1;
                            s_nxt.ctrl = s_r.ctrl;
                        end else begin
                            s_nxt.busy = 1'b1;
                            s_nxt.done = 1'b0;
                            s_nxt.refused = 1'b0;
                        end
                    end
                end
                `FCD_AXI_WDATA: begin
                    if (!s_r.busy) begin
                        s_nxt.wdata = (s_r.wdata & ~wmask) | wmerged;
                    end
                end
                `FCD_AXI_STAT, `FCD_AXI_RDATA: s_nxt.bresp = `FCD_RESP_OK;
                default: s_nxt.bresp = `FCD_RESP_ERR;
            endcase
        end
        if (arvalid && arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `FCD_RESP_OK;
            case (araddr)
                `FCD_AXI_CTRL: s_nxt.rdat = {22'h000000, s_r.ctrl};
                `FCD_AXI_WDATA: s_nxt.rdat = {16'h0000, s_r.wdata};
                `FCD_AXI_STAT: s_nxt.rdat = {29'h00000000, s_r.refused, s_r.done, s_r.busy};
                `FCD_AXI_RDATA: s_nxt.rdat = {16'h0000, s_r.rdata};
                default: begin
                    s_nxt.rdat = 32'h00000000;
                    s_nxt.rresp = `FCD_RESP_ERR;
                end
            endcase
        end
        case (s_r.st)
            FCD_H_IDLE: begin
                if (s_r.busy) begin
                    s_nxt.req = 1'b1;
                    if (s_r.ctrl[`FCD_CTRL_WR] && s_r.ctrl[7:0] == `FCD_OFS_SUPPLY && !s_r.sup_v) begin
                        s_nxt.st = FCD_H_FETCH;
                        s_nxt.we = 1'b0;
                        s_nxt.addr = `FCD_OFS_SUPPLY;
                    end else begin
                        s_nxt.st = FCD_H_XFER;
                        s_nxt.we = s_r.ctrl[`FCD_CTRL_WR];
                        s_nxt.addr = s_r.ctrl[7:0];
                        s_nxt.data = patched;
                    end
                end
            end
            FCD_H_FETCH: begin
                if (bus.ack) begin
                    s_nxt.sup = bus.rdata[`FCD_BIT_SUP_HI:`FCD_BIT_SUP_LO];
                    s_nxt.sup_v = 1'b1;
                    s_nxt.req = 1'b0;
                    s_nxt.st = FCD_H_IDLE;
                end
            end
            FCD_H_XFER: begin
                if (bus.ack) begin
                    if (!s_r.we && s_r.addr == `FCD_OFS_SUPPLY) begin
                        s_nxt.sup = bus.rdata[`FCD_BIT_SUP_HI:`FCD_BIT_SUP_LO];
                        s_nxt.sup_v = 1'b1;
                    end
                    s_nxt.rdata = bus.rdata;
                    s_nxt.req = 1'b0;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.st = FCD_H_IDLE;
                end
            end
            default: s_nxt.st = FCD_H_IDLE;
        endcase
        if (!aresetn) begin
            s_nxt = '0;
            s_nxt.st = FCD_H_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    assign awready = !s_r.aw_have;
    assign wready = !s_r.w_have;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = !s_r.rvalid;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdat;
    assign rresp = s_r.rresp;
    assign bus.req = s_r.req;
    assign bus.we = s_r.we;
    assign bus.addr = s_r.addr;
    assign bus.wdata = s_r.data;
endmodule // fcd_host
`default_nettype wire

// >>> rtl/fcd_map.svh
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
`define FCD_OFS_SUPPLY 8'h00
`define FCD_OFS_NUM_HI 8'h01
`define FCD_OFS_NUM_LO 8'h02
`define FCD_OFS_DIVSEL 8'h03
`define FCD_OFS_UNLOCK 8'h0c
`define FCD_RST_SUPPLY 16'h0861
`define FCD_RST_NUM_HI 16'h5599
`define FCD_RST_NUM_LO 16'hc28f
`define FCD_RST_DIVSEL 16'h1804
`define FCD_UNLOCK_KEY 8'h5b
`define FCD_NUM_HI_RSV 8'h99
`define FCD_BIT_FUSE 0
`define FCD_BIT_SUP_LO 1
`define FCD_BIT_SUP_HI 2
`define FCD_BIT_RSV3 3
`define FCD_BIT_CH0_SEL 4
`define FCD_BIT_AB_OFF 5
`define FCD_BIT_CD_OFF 6
`define FCD_BIT_RSV7 7
`define FCD_BIT_CH1_SEL 8
`define FCD_HALF_C1 5'h01
`define FCD_HALF_C2 5'h02
`define FCD_HALF_C3 5'h03
`define FCD_HALF_C4 5'h04
`define FCD_HALF_C5 5'h05
`define FCD_HALF_C6 5'h0a
`define FCD_HALF_C7 5'h14
`define FCD_AXI_CTRL 8'h00
`define FCD_AXI_WDATA 8'h04
`define FCD_AXI_STAT 8'h08
`define FCD_AXI_RDATA 8'h0c
`define FCD_CTRL_WR 8
`define FCD_CTRL_GO 9
`define FCD_RESP_OK 2'h0
`define FCD_RESP_ERR 2'h2
`endif

// >>> rtl/fcd_pkg.sv
`default_nettype none
package fcd_pkg;
    typedef struct packed {
        logic [2:0] code;
        logic [4:0] cnt;
        logic out;
    } fcd_div_st_t;
    typedef struct packed {
        logic [15:0] r0;
        logic [15:0] r1;
        logic [15:0] r2;
        logic [15:0] r3;
        logic [7:0] unlock;
        logic loaded;
        logic ack;
        logic [15:0] rdata;
        logic [3:0] pin_o;
        logic [3:0] pin_oe;
        logic ch1_tick;
    } fcd_dev_st_t;
    typedef enum logic [1:0] {
        FCD_H_IDLE,
        FCD_H_FETCH,
        FCD_H_XFER
    } fcd_hstate_t;
    typedef struct packed {
        fcd_hstate_t st;
        logic [9:0] ctrl;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic busy;
        logic done;
        logic refused;
        logic [1:0] sup;
        logic sup_v;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [15:0] data;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdat;
        logic [1:0] rresp;
    } fcd_host_st_t;
endpackage
`default_nettype wire

// >>> rtl/fcd_if.sv
`default_nettype none
interface fcd_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
    modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// >>> rtl/fcd_chan_div.sv
`include "fcd_map.svh"
`default_nettype none
module fcd_chan_div
    import fcd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] code,
    input wire logic tick,
    output logic clk_out
);
    fcd_div_st_t s_r;
    fcd_div_st_t s_nxt;
    logic [4:0] half;

    always_comb begin
        case (s_r.code)
            3'h1: half = `FCD_HALF_C1;
            3'h2: half = `FCD_HALF_C2;
            3'h3: half = `FCD_HALF_C3;
            3'h4: half = `FCD_HALF_C4;
            3'h5: half = `FCD_HALF_C5;
            3'h6: half = `FCD_HALF_C6;
            3'h7: half = `FCD_HALF_C7;
            default: half = `FCD_HALF_C1;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        if (!aresetn) begin
            s_nxt = '0;
        end else if (s_r.code == 3'h0) begin
            s_nxt.out = 1'b0;
            s_nxt.cnt = 5'h00;
            s_nxt.code = code;
        end else if (tick) begin
            s_nxt.cnt = s_r.cnt + 5'h01;
            if (s_nxt.cnt == half) begin
                s_nxt.cnt = 5'h00;
                s_nxt.out = ~s_r.out;
                if (s_r.out) begin
                    s_nxt.code = code;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    assign clk_out = s_r.out;
endmodule // fcd_chan_div
`default_nettype wire

// >>> rtl/fcd_device.sv
`include "fcd_map.svh"
`default_nettype none
module fcd_device
    import fcd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    fcd_if.dev bus,
    input wire logic [15:0] fuse_supply,
    input wire logic [15:0] fuse_num_hi,
    input wire logic [15:0] fuse_num_lo,
    input wire logic [15:0] fuse_divsel,
    input wire logic frac_div0_tick,
    input wire logic frac_div1_tick,
    input wire logic chan1_clk,
    input wire logic outputs_ab_enable,
    input wire logic outputs_cd_enable,
    output logic [1:0] core_supply_level,
    output logic fuse_programmed_flag,
    output logic [23:0] frac_div0_numerator,
    output logic [6:0] frac_div1_integer_ratio,
    output logic chan1_source_tick,
    output logic chan0_clk,
    output logic output_first_o,
    output logic output_first_oe,
    output logic output_second_o,
    output logic output_second_oe,
    output logic output_third_o,
    output logic output_third_oe,
    output logic output_fourth_o,
    output logic output_fourth_oe
);
    fcd_dev_st_t s_r;
    fcd_dev_st_t s_nxt;
    logic unlocked;
    logic ch0_tick;
    logic div_out;
    logic [15:0] rd_val;

    // Locked fields take writes only while the unlock byte holds the key.
    assign unlocked = (s_r.unlock == `FCD_UNLOCK_KEY);

    // Channel divider 0 counts ticks of the fractional divider that bit 4 selects.
    always_comb begin
        if (s_r.r3[`FCD_BIT_CH0_SEL]) begin
            ch0_tick = frac_div1_tick;
        end else begin
            ch0_tick = frac_div0_tick;
        end
    end

    // The divider flop drives channel 0 and the first output pair.
    fcd_chan_div u_ch0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .code(s_r.r3[2:0]),
        .tick(ch0_tick),
        .clk_out(div_out)
    );

    // Each mapped offset returns its whole register word.
    always_comb begin
        case (bus.addr)
            `FCD_OFS_SUPPLY: begin
                rd_val = s_r.r0;
            end
            `FCD_OFS_NUM_HI: begin
                rd_val = s_r.r1;
            end
            `FCD_OFS_NUM_LO: begin
                rd_val = s_r.r2;
            end
            `FCD_OFS_DIVSEL: begin
                rd_val = s_r.r3;
            end
            `FCD_OFS_UNLOCK: begin
                rd_val = {8'h00, s_r.unlock};
            end
            default: begin
                rd_val = 16'h0000;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        // The answer pulse lasts one cycle.
        s_nxt.ack = 1'b0;
        if (!aresetn) begin
            // Reset values stand until the fuse page is loaded.
            s_nxt = '0;
            s_nxt.r0 = `FCD_RST_SUPPLY;
            s_nxt.r1 = `FCD_RST_NUM_HI;
            s_nxt.r2 = `FCD_RST_NUM_LO;
            s_nxt.r3 = `FCD_RST_DIVSEL;
        end else if (!s_r.loaded) begin
            // One edge after reset the fuse page takes over.
            s_nxt.r0 = fuse_supply;
            s_nxt.r1 = fuse_num_hi;
            s_nxt.r2 = fuse_num_lo;
            s_nxt.r3 = fuse_divsel;
            s_nxt.loaded = 1'b1;
        end else if (bus.req && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            // A write answers with the old contents.
            s_nxt.rdata = rd_val;
            if (bus.we) begin
                case (bus.addr)
                    `FCD_OFS_SUPPLY: begin
                        s_nxt.r0[15:1] = bus.wdata[15:1];
                        // Bit 0 is locked; the other bits follow the host.
                        if (unlocked) begin
                            s_nxt.r0[`FCD_BIT_FUSE] = bus.wdata[`FCD_BIT_FUSE];
                        end
                    end
                    `FCD_OFS_NUM_HI: begin
                        s_nxt.r1 = bus.wdata;
                    end
                    `FCD_OFS_NUM_LO: begin
                        s_nxt.r2 = bus.wdata;
                    end
                    `FCD_OFS_DIVSEL: begin
                        s_nxt.r3 = bus.wdata;
                    end
                    `FCD_OFS_UNLOCK: begin
                        s_nxt.unlock = bus.wdata[7:0];
                    end
                    default: begin
                        s_nxt.unlock = s_r.unlock;
                    end
                endcase
            end
        end

        // Channel divider 1 takes the tick that bit 8 selects, one cycle late.
        s_nxt.ch1_tick = s_r.r3[`FCD_BIT_CH1_SEL] ? frac_div1_tick : frac_div0_tick;

        // A disabled pair drives low, or floats when its off-state bit is set.
        if (outputs_ab_enable) begin
            s_nxt.pin_o[1:0] = {2{div_out}};
            s_nxt.pin_oe[1:0] = 2'h3;
        end else begin
            s_nxt.pin_o[1:0] = 2'h0;
            s_nxt.pin_oe[1:0] = {2{~s_r.r3[`FCD_BIT_AB_OFF]}};
        end

        if (outputs_cd_enable) begin
            s_nxt.pin_o[3:2] = {2{chan1_clk}};
            s_nxt.pin_oe[3:2] = 2'h3;
        end else begin
            s_nxt.pin_o[3:2] = 2'h0;
            s_nxt.pin_oe[3:2] = {2{~s_r.r3[`FCD_BIT_CD_OFF]}};
        end

        // Pins stay released while reset is held.
        if (!aresetn) begin
            s_nxt.pin_o = 4'h0;
            s_nxt.pin_oe = 4'h0;
            s_nxt.ch1_tick = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    // Every output comes straight from a state flop.
    assign bus.ack = s_r.ack;
    assign bus.rdata = s_r.rdata;

    // Register fields used by the clock path.
    assign core_supply_level = s_r.r0[`FCD_BIT_SUP_HI:`FCD_BIT_SUP_LO];
    assign fuse_programmed_flag = s_r.r0[`FCD_BIT_FUSE];
    assign frac_div0_numerator = {s_r.r1[15:8], s_r.r2};
    assign frac_div1_integer_ratio = s_r.r3[15:9];

    assign chan1_source_tick = s_r.ch1_tick;
    assign chan0_clk = div_out;

    // Pin drive and enable, one flop each.
    assign output_first_o = s_r.pin_o[0];
    assign output_first_oe = s_r.pin_oe[0];
    assign output_second_o = s_r.pin_o[1];
    assign output_second_oe = s_r.pin_oe[1];
    assign output_third_o = s_r.pin_o[2];
    assign output_third_oe = s_r.pin_oe[2];
    assign output_fourth_o = s_r.pin_o[3];
    assign output_fourth_oe = s_r.pin_oe[3];
endmodule // fcd_device
`default_nettype wire

// >>> verification/fcd_link_checker.sv
`default_nettype none
module fcd_link_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] sup_r;
    logic sup_v_r;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Remembers the supply code last read back from the device.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sup_r <= 2'h0;
            sup_v_r <= 1'h0;
        end else if (ack && !we && addr == 8'h00) begin
            sup_r <= rdata[2:1];
            sup_v_r <= 1'h1;
        end
    end
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    ack_has_req_a: assert property (ack |-> req)
        else $error("ack without request");
    req_held_a: assert property (req && !ack |=> req)
        else $error("request dropped before ack");
    req_stable_a: assert property (req && !ack |=> $stable({we, addr, wdata}))
        else $error("request fields changed while pending");
    req_answered_a: assert property ($rose(req) |-> ##[1:3] ack)
        else $error("request not answered in time");
    req_released_a: assert property (ack |=> !req)
        else $error("request not released after ack");
    rsv_low_byte_a: assert property (req && we && addr == 8'h01 |-> wdata[7:0] == 8'h99)
        else $error("reserved byte written with wrong value");
    rsv_bit7_a: assert property (req && we && addr == 8'h03 |-> !wdata[7])
        else $error("reserved bit 7 written with one");
    rsv_bit3_a: assert property (req && we && addr == 8'h03 |-> !wdata[3])
        else $error("reserved bit 3 written with one");
    supply_kept_a: assert property (req && we && addr == 8'h00 && sup_v_r
        |-> wdata[2:1] == sup_r)
        else $error("supply code overwritten");
    cover property (ack && we);
    cover property (ack && !we);
    cover property (req && we && addr == 8'h0c);
endmodule // fcd_link_checker
`default_nettype wire

// >>> verification/tb_fod_channel_divider_config.sv
`default_nettype none
module tb_fod_channel_divider_config;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic tick0 = 1'h0;
    logic tick1 = 1'h1;
    logic ch1clk = 1'h0;
    logic ab_en = 1'h1;
    logic cd_en = 1'h1;
    logic awready, wready, bvalid, arready, rvalid, fuse_flag, src_tick, ch0;
    logic [1:0] bresp, rresp, sup_lvl;
    logic [31:0] rdata;
    logic [15:0] fz [4];
    logic [23:0] num;
    logic [6:0] ratio;
    wire [3:0] po;
    wire [3:0] poe;
    int err_total = 0;
    int tests_run = 0;
    int seed = 51;
    fcd_if link ();
    fcd_host u_fcd_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .bus(link));
    fcd_device u_fcd_device (.aclk(aclk), .aresetn(aresetn), .bus(link), .fuse_supply(fz[0]),
        .fuse_num_hi(fz[1]), .fuse_num_lo(fz[2]), .fuse_divsel(fz[3]), .frac_div0_tick(tick0),
        .frac_div1_tick(tick1), .chan1_clk(ch1clk), .outputs_ab_enable(ab_en),
        .outputs_cd_enable(cd_en), .core_supply_level(sup_lvl), .fuse_programmed_flag(fuse_flag),
        .frac_div0_numerator(num), .frac_div1_integer_ratio(ratio), .chan1_source_tick(src_tick),
        .chan0_clk(ch0), .output_first_o(po[0]), .output_first_oe(poe[0]),
        .output_second_o(po[1]), .output_second_oe(poe[1]), .output_third_o(po[2]),
        .output_third_oe(poe[2]), .output_fourth_o(po[3]), .output_fourth_oe(poe[3]));
    fcd_link_checker u_fcd_link_checker (.aclk(aclk), .aresetn(aresetn), .req(link.req),
        .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
    always #2 aclk = ~aclk;
    // The first fractional divider ticks every other cycle, the second every cycle.
    always @(posedge aclk) begin
        tick0 <= ~tick0;
        ch1clk <= ~ch1clk;
    end
    function automatic int div_of(input logic [2:0] c);
        int t[8] = '{0, 2, 4, 6, 8, 10, 20, 40};
        return t[c];
    endfunction
    function automatic logic [15:0] mk3(input logic [6:0] r, input logic s1,
        input logic [1:0] off, input logic s0, input logic [2:0] c);
        return {r, s1, 1'h0, off, s0, 1'h0, c};
    endfunction
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic give_up(input string what);
        err_total++;
        $display("unexpected at %0t: wait for %s ran out", $time, what);
        finish_test();
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_p;
        logic w_p;
        int n;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'h1;
        aw_p = 1'h1;
        w_p = 1'h1;
        n = 0;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && awready === 1'h1) begin
                aw_p = 1'h0;
                awvalid <= 1'h0;
            end
            if (w_p && wready === 1'h1) begin
                w_p = 1'h0;
                wvalid <= 1'h0;
            end
            n++;
            if (n > 50) give_up("write address");
        end
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (n > 100) give_up("write response");
        end while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n > 50) give_up("read address");
        end while (arready !== 1'h1);
        arvalid <= 1'h0;
        do begin
            @(posedge aclk);
            n++;
            if (n > 100) give_up("read data");
        end while (rvalid !== 1'h1);
        d = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask
    // One device transfer: stage data, issue the command, poll until done, fetch result.
    task automatic dev_cmd(input logic [7:0] off, input logic wr, input logic [15:0] d,
        output logic [15:0] q);
        logic [1:0] r;
        logic [31:0] s;
        int n;
        if (wr) axi_wr(8'h04, {16'h0, d}, r);
        axi_wr(8'h00, {22'h0, 1'h1, wr, off}, r);
        n = 0;
        do begin
            axi_rd(8'h08, s, r);
            n++;
            if (n > 40) give_up("device transfer");
        end while (s[1:0] !== 2'h2);
        axi_rd(8'h0c, s, r);
        q = s[15:0];
    endtask
    task automatic wait_lvl(input logic v, inout int n);
        do begin
            @(posedge aclk);
            n++;
            if (n > 400) give_up("divider edge");
        end while (ch0 !== v);
    endtask
    task automatic meas(output int p);
        int n;
        n = 0;
        wait_lvl(1'h0, n);
        wait_lvl(1'h1, n);
        wait_lvl(1'h0, n);
        wait_lvl(1'h1, n);
        n = 0;
        wait_lvl(1'h0, n);
        wait_lvl(1'h1, n);
        p = n;
    endtask
    initial begin
        logic [15:0] q;
        logic [15:0] q2;
        logic [31:0] d;
        logic [23:0] f;
        logic [1:0] r;
        int p;
        int n;
        fz[0] = {13'h010c, 2'($unsigned($random(seed)) % 3), 1'h1};
        fz[1] = {8'($random(seed)), 8'h99};
        fz[2] = 16'($random(seed));
        fz[3] = 16'($random(seed)) & 16'hff77;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        chk_word(32'(num), {8'h0, fz[1][15:8], fz[2]}, "numerator");
        chk_word(32'(ratio), 32'(fz[3][15:9]), "ratio");
        chk_word(32'({sup_lvl, fuse_flag}), 32'(fz[0][2:0]), "supply and flag");
        for (int i = 0; i < 4; i++) begin
            dev_cmd(8'(i), 1'h0, 16'h0, q);
            chk_word(32'(q), 32'(fz[i]), "fuse page");
        end
        axi_rd(8'h10, d, r);
        chk_word(32'(r), 32'h2, "unmapped read");
        axi_wr(8'h14, 32'h0, r);
        chk_word(32'(r), 32'h2, "unmapped write");
        $display("test fuse page finished");
        for (int i = 0; i < 4; i++) begin
            f = i == 0 ? 24'hffffff : i == 1 ? 24'h0 : 24'($random(seed));
            dev_cmd(8'h01, 1'h1, {f[23:16], 8'h99}, q);
            dev_cmd(8'h02, 1'h1, f[15:0], q);
            dev_cmd(8'h01, 1'h0, 16'h0, q);
            chk_word(32'(q), {16'h0, f[23:16], 8'h99}, "numerator high");
            dev_cmd(8'h02, 1'h0, 16'h0, q);
            chk_word(32'(q), 32'(f[15:0]), "numerator low");
            chk_word(32'(num), 32'(f), "numerator out");
        end
        $display("test numerator finished");
        dev_cmd(8'h00, 1'h0, 16'h0, q);
        dev_cmd(8'h00, 1'h1, q & 16'hfffe, q2);
        dev_cmd(8'h00, 1'h0, 16'h0, q2);
        chk_word(32'(q2), 32'(q), "locked flag");
        dev_cmd(8'h0c, 1'h1, 16'h005b, q2);
        dev_cmd(8'h00, 1'h1, q & 16'hfffe, q2);
        dev_cmd(8'h00, 1'h0, 16'h0, q2);
        chk_word(32'(q2), 32'(q & 16'hfffe), "unlocked flag");
        chk_word(32'(fuse_flag), 32'h0, "flag output");
        $display("test unlock finished");
        for (int i = 0; i < 16; i++) begin
            dev_cmd(8'h03, 1'h1, mk3(fz[3][15:9], 1'h0, 2'h0, i[3], i[2:0]), q);
            if (i[2:0] == 3'h0) begin
                // The old code runs to its next falling edge, at most 80 cycles away.
                repeat (100) @(posedge aclk);
                n = 0;
                repeat (60) begin
                    @(posedge aclk);
                    n += (ch0 !== 1'h0);
                end
                chk_word(32'(n), 32'h0, "stopped divider");
            end else begin
                meas(p);
                chk_word(32'(p), 32'(div_of(i[2:0]) * (i[3] ? 1 : 2)), "period");
            end
        end
        $display("test channel divider finished");
        for (int s = 0; s < 2; s++) begin
            dev_cmd(8'h03, 1'h1, mk3(7'h0c, s[0], 2'h0, 1'h0, 3'h4), q);
            n = 0;
            repeat (8) begin
                @(posedge aclk);
                n += (src_tick === 1'h1);
            end
            chk_word(32'(n), s ? 32'h8 : 32'h4, "source ticks");
        end
        for (int v = 0; v < 4; v++) begin
            dev_cmd(8'h03, 1'h1, mk3(7'h0c, 1'h0, v[1:0], 1'h0, 3'h4), q);
            ab_en <= 1'h0;
            cd_en <= 1'h0;
            repeat (3) @(posedge aclk);
            chk_word({24'h0, po, poe}, {28'h0, {2{~v[1]}}, {2{~v[0]}}}, "off pins");
            ab_en <= 1'h1;
            cd_en <= 1'h1;
            repeat (3) @(posedge aclk);
            chk_word(32'(poe), 32'hf, "on pins");
        end
        $display("test sources and pins finished");
        finish_test();
    end
endmodule // tb_fod_channel_divider_config
`default_nettype wire
